// file: apc_consts.vh
// Purpose: shared constants of the converter power and coding control
// Assumes: 250 MHz system clock
// Notes: APB word offsets, field positions, reset values, timing counts
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH

`define APC_CLK_PERIOD_NS 4
`define APC_WAKE_NS 5000
`define APC_WAKE_CYCLES ((`APC_WAKE_NS + `APC_CLK_PERIOD_NS - 1) / `APC_CLK_PERIOD_NS)
`define APC_CONV_NS 4600
`define APC_CONV_CYCLES ((`APC_CONV_NS + `APC_CLK_PERIOD_NS - 1) / `APC_CLK_PERIOD_NS)

`define APC_ADDR_CTRL 8'h00
`define APC_ADDR_STATUS 8'h04
`define APC_ADDR_RESULT 8'h08

`define APC_CTRL_PM_LOW 0
`define APC_CTRL_PM_HIGH 1
`define APC_CTRL_BIPOLAR 2
`define APC_CTRL_SW_START 3
`define APC_CTRL_RESET 4'h0

`define APC_STAT_BUSY 0
`define APC_STAT_MODE_LSB 1
`define APC_STAT_ANALOG_ON 3
`define APC_STAT_REF_ON 4

`define APC_MODE_UP 2'h0
`define APC_MODE_DOWN 2'h1
`define APC_MODE_BETWEEN_FULL 2'h2
`define APC_MODE_BETWEEN_PART 2'h3

`define APC_RESULT_BITS 12
`define APC_BIPOLAR_FLIP 12'h800

`endif

// file: apc_coder.v
// Purpose: output code format of one conversion result
// Assumes: raw sample is straight binary from the converter core
// Notes: bipolar code is two's complement about mid-scale
`timescale 1ns/1ns
`include "apc_consts.vh"

module apc_coder (
	// sample in
	input wire [`APC_RESULT_BITS-1:0] rawCode,
	input wire bipolar,
	// coded out
	output wire [`APC_RESULT_BITS-1:0] codedResult
);

	// mid-scale maps to zero, so flipping the top bit is the whole job
	assign codedResult = bipolar ? (rawCode ^ `APC_BIPOLAR_FLIP) : rawCode;

endmodule // apc_coder

// file: apc_power_ctrl.v
// Purpose: power state and conversion sequencing with APB control
// Assumes: pins are asynchronous, raw sample is on clk
// Notes: pready is always high, reads are prepared in the setup cycle
// Notes on behaviour
// - unipolar results are straight binary
// - bipolar results are two's complement about mid-scale
// - results are 12 bits, LSB is FS/4096
// - code transitions sit at half-LSB points
// - power state from two bits and sleep pin
// - full down kills all; partial keeps reference
// - bits 00, pin high: always fully powered
// - bits 00, pin low: down between conversions
// - bits 10: full power-down, pin ignored
// - busy falls when result becomes readable
// - between-modes power down when busy falls
// - start falling edge wakes; ready 5 us later
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "apc_consts.vh"

module apc_power_ctrl #(
	parameter WAKE_CYCLES = `APC_WAKE_CYCLES,
	parameter CONV_CYCLES = `APC_CONV_CYCLES
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// pins
	input wire conversion_start_pin_n,
	input wire sleep_pin_n,
	output reg busy,
	// converter core
	input wire [`APC_RESULT_BITS-1:0] rawSample,
	output reg analogPowerOn,
	output reg referencePowerOn,
	output reg [`APC_RESULT_BITS-1:0] resultData
);

	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_CONV = 5'h02;
	localparam [4:0] S_SLEEP = 5'h04;
	localparam [4:0] S_WAKE = 5'h08;

	reg [4:0] state;
	reg [4:0] next_state;
	reg [11:0] count;
	reg [3:0] ctrl;
	reg startSync1, startSync2, startPrev;
	reg sleepSync1, sleepSync2;
	reg pendingStart;
	wire startFall;
	wire startRise;
	wire [1:0] mode;
	wire betweenMode;
	wire countDone;
	wire wrEn;
	wire rdSetup;
	wire mapped;
	wire endOfConv;
	wire [`APC_RESULT_BITS-1:0] coded;

	////////////////////////////////////////////////////////////////
	// power mode decode

	function [1:0] decodeMode;
		input hi;
		input lo;
		input sleepN;
		begin
			case ({hi, lo})
				2'h0: decodeMode = sleepN ? `APC_MODE_UP : `APC_MODE_BETWEEN_FULL;
				2'h1: decodeMode = `APC_MODE_BETWEEN_FULL;
				2'h2: decodeMode = `APC_MODE_DOWN;
				default: decodeMode = `APC_MODE_BETWEEN_PART;
			endcase
		end
	endfunction

	assign mode = decodeMode(ctrl[`APC_CTRL_PM_HIGH], ctrl[`APC_CTRL_PM_LOW],
		sleepSync2);
	assign betweenMode = (mode == `APC_MODE_BETWEEN_FULL) ||
		(mode == `APC_MODE_BETWEEN_PART);

	////////////////////////////////////////////////////////////////
	// pin synchronisers

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			startSync1 <= 1'b1;
			startSync2 <= 1'b1;
			startPrev <= 1'b1;
			sleepSync1 <= 1'b1;
			sleepSync2 <= 1'b1;
		end else begin
			startSync1 <= conversion_start_pin_n;
			startSync2 <= startSync1;
			startPrev <= startSync2;
			sleepSync1 <= sleep_pin_n;
			sleepSync2 <= sleepSync1;
		end
	end

	assign startFall = startPrev && !startSync2;
	assign startRise = !startPrev && startSync2;

	////////////////////////////////////////////////////////////////
	// sequencer

	assign countDone = (count == 12'h000);
	assign endOfConv = (state == S_CONV) && countDone;

	always @* begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (mode == `APC_MODE_DOWN)
					next_state = S_SLEEP;
				else if (startRise || ctrl[`APC_CTRL_SW_START])
					next_state = S_CONV;
			end
			S_CONV: begin
				if (countDone)
					next_state = (betweenMode || mode == `APC_MODE_DOWN) ?
						S_SLEEP : S_IDLE;
			end
			S_SLEEP: begin
				if (mode == `APC_MODE_UP)
					next_state = S_WAKE;
				else if (betweenMode &&
					(startFall || ctrl[`APC_CTRL_SW_START]))
					next_state = S_WAKE;
			end
			S_WAKE: begin
				if (countDone) begin
					if (mode == `APC_MODE_DOWN)
						next_state = S_SLEEP;
					// a rise in the last wake cycle is not yet pending
					else if (pendingStart || startRise ||
						ctrl[`APC_CTRL_SW_START])
						next_state = S_CONV;
					else
						next_state = S_IDLE;
				end
			end
			default: next_state = S_SLEEP;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			count <= 12'h000;
			pendingStart <= 1'b0;
			busy <= 1'b0;
			resultData <= 12'h000;
		end else begin
			state <= next_state;
			if (next_state == S_CONV && state != S_CONV)
				count <= CONV_CYCLES[11:0] - 12'h001;
			else if (next_state == S_WAKE && state != S_WAKE)
				count <= WAKE_CYCLES[11:0] - 12'h001;
			else if (!countDone)
				count <= count - 12'h001;
			// a start edge during wake-up is held until the core is ready
			if (state == S_WAKE && startRise)
				pendingStart <= 1'b1;
			else if (state != S_WAKE)
				pendingStart <= 1'b0;
			busy <= (next_state == S_CONV);
			if (endOfConv)
				resultData <= coded;
		end
	end

	// reference stays up only in partial mode while the rest sleeps
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			analogPowerOn <= 1'b1;
			referencePowerOn <= 1'b1;
		end else begin
			analogPowerOn <= (next_state != S_SLEEP);
			referencePowerOn <= (next_state != S_SLEEP) ||
				(mode == `APC_MODE_BETWEEN_PART);
		end
	end

	apc_coder uCoder (
		.rawCode(rawSample),
		.bipolar(ctrl[`APC_CTRL_BIPOLAR]),
		.codedResult(coded)
	);

	////////////////////////////////////////////////////////////////
	// apb slave

	assign pready = 1'b1;
	assign wrEn = psel && penable && pwrite;
	assign rdSetup = psel && !penable && !pwrite;
	assign mapped = (paddr == `APC_ADDR_CTRL) ||
		(paddr == `APC_ADDR_STATUS) || (paddr == `APC_ADDR_RESULT);
	assign pslverr = psel && penable && !mapped;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `APC_CTRL_RESET;
		end else begin
			if (wrEn && paddr == `APC_ADDR_CTRL)
				ctrl <= pwdata[3:0];
			// set by a write in the same cycle wins over the clear
			else if (endOfConv)
				ctrl[`APC_CTRL_SW_START] <= 1'b0;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (rdSetup) begin
			if (paddr == `APC_ADDR_CTRL)
				prdata <= {28'h0000000, ctrl};
			else if (paddr == `APC_ADDR_STATUS)
				prdata <= {27'h0000000, referencePowerOn, analogPowerOn,
					mode, busy};
			else if (paddr == `APC_ADDR_RESULT)
				prdata <= {20'h00000, resultData};
			else
				prdata <= 32'h00000000;
		end
	end

endmodule // apc_power_ctrl

// file: apc_power_ctrl_props.sv
// Purpose: port checker of power state and result coding
// Assumes: ctrl bits are tracked from apb writes
// Notes: pins are held steady around each conversion end
`timescale 1ns/1ns
`include "apc_consts.vh"
module apc_power_ctrl_props #(
	parameter WAKE_CYCLES = 8,
	parameter CONV_CYCLES = 8
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	// pins and core
	input wire conversion_start_pin_n,
	input wire sleep_pin_n,
	input wire busy,
	input wire [`APC_RESULT_BITS-1:0] rawSample,
	input wire analogPowerOn,
	input wire referencePowerOn,
	input wire [`APC_RESULT_BITS-1:0] resultData
);
	localparam int LIM0 = WAKE_CYCLES + CONV_CYCLES + 16;
	// long real counts are capped to keep the window tractable
	localparam int LIM = (LIM0 > 1000) ? 1000 : LIM0;
	reg [2:0] ctl;
	wire [1:0] pm = ctl[1:0];
	wire [11:0] flip = ctl[2] ? 12'h800 : 12'h000;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ctl <= 3'h0;
		else if (psel && penable && pwrite && paddr == 8'h00)
			ctl <= pwdata[2:0];
	end
	////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_done;
		$fell(busy);
	endsequence
	sequence s_wake;
		!analogPowerOn && pm != 2'h2 && $fell(conversion_start_pin_n);
	endsequence
	chk_ref_gate: assert property (!referencePowerOn |-> !analogPowerOn)
		else $error("analog on without reference");
	chk_up_stays: assert property
		(pm == 2'h0 && sleep_pin_n && $past(sleep_pin_n, 2) &&
		analogPowerOn |=> analogPowerOn)
		else $error("power lost in full up");
	chk_up_after: assert property
		(s_done ##0 ($past(pm) == 2'h0 && $past(sleep_pin_n, 3))
		|-> analogPowerOn)
		else $error("power lost after conversion");
	chk_gap_full: assert property
		(s_done ##0 ($past(pm) == 2'h1 ||
		($past(pm) == 2'h0 && !$past(sleep_pin_n, 3)))
		|-> !analogPowerOn && !referencePowerOn)
		else $error("no full down after conversion");
	chk_gap_part: assert property
		(s_done ##0 ($past(pm) == 2'h3) |-> !analogPowerOn &&
		referencePowerOn)
		else $error("no partial down after conversion");
	chk_full_down: assert property
		(pm == 2'h2 && !busy |-> ##[1:LIM] !analogPowerOn && !referencePowerOn)
		else $error("full down not reached");
	chk_code_fmt: assert property
		(s_done |-> resultData == ($past(rawSample) ^ $past(flip)))
		else $error("result coding wrong");
	chk_wake_hold: assert property (s_wake |-> !busy [*8] ##[1:LIM] busy)
		else $error("conversion timing after wake wrong");
endmodule // apc_power_ctrl_props

bind apc_power_ctrl apc_power_ctrl_props #(
	.WAKE_CYCLES(WAKE_CYCLES),
	.CONV_CYCLES(CONV_CYCLES)
) apc_power_ctrl_props_i (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.conversion_start_pin_n(conversion_start_pin_n),
	.sleep_pin_n(sleep_pin_n), .busy(busy), .rawSample(rawSample),
	.analogPowerOn(analogPowerOn), .referencePowerOn(referencePowerOn),
	.resultData(resultData));

// file: apc_host_model.sv
// Purpose: host driver of the start pin
// Assumes: one pulse request at a time
// Notes: low time must cover the wake time
`timescale 1ns/1ns
module apc_host_model (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// request
	input wire go,
	input wire [4:0] lowLen,
	// pin
	output reg startN
);
	reg [4:0] left;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			startN <= 1'b1;
			left <= 5'h00;
		end else if (go && left == 5'h00) begin
			startN <= 1'b0;
			left <= lowLen;
		end else if (left != 5'h00) begin
			left <= left - 5'h01;
			startN <= (left == 5'h01);
		end
	end
endmodule // apc_host_model

// file: apc_power_ctrl_tb.sv
// Purpose: bench of power modes and result coding
// Assumes: short wake and conversion counts
// Notes: results are queued at start, compared at busy fall
`timescale 1ns/1ns
module apc_power_ctrl_tb;
	logic clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic go = 1'b0, sleepN = 1'b1, busy, aOn, rOn, pready, pslverr, startN;
	logic wasBusy = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h20612F94;
	logic [11:0] raw = 12'h000, res, lastE, q[$];
	logic [4:0] lowLen = 5'h0C;
	int miscompares = 0, num_checks = 0, i;
	apc_power_ctrl #(.WAKE_CYCLES(8), .CONV_CYCLES(8)) apc_power_ctrl_i (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conversion_start_pin_n(startN),
		.sleep_pin_n(sleepN), .busy(busy), .rawSample(raw),
		.analogPowerOn(aOn), .referencePowerOn(rOn), .resultData(res));
	apc_host_model apc_host_model_i (.clk(clk), .rst_n(rst_n), .go(go),
		.lowLen(lowLen), .startN(startN));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task results();
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// expectation noted before the start so the watcher never runs dry
	task conv(input logic [2:0] c, input logic sw);
		lastE = 12'(xs());
		raw <= lastE;
		lastE = lastE ^ (c[2] ? 12'h800 : 12'h000);
		q.push_back(lastE);
		if (sw) begin
			apb(1'b1, 8'h00, {28'h0, 1'b1, c});
		end else begin
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
		end
		@(negedge busy);
		@(posedge clk);
	endtask
	always @(negedge clk) begin
		if (wasBusy === 1'b1 && busy === 1'b0 && q.size() > 0)
			chk("result", {20'h0, q.pop_front()}, {20'h0, res});
		else if (wasBusy === 1'b1 && busy === 1'b0) begin
			miscompares++;
			$display("[ERR] result exp queued-entry got %h", res);
		end
		wasBusy = busy;
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, 8'h04, 32'h0);
		chk("status", 32'h00000018, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
		for (i = 0; i < 8; i++) begin
			sleepN <= (i != 4);
			// 8 is the shortest legal low time, rise in last wake cycle
			lowLen <= (i == 3) ? 5'h08 : (i[0] ? 5'h14 : 5'h0C);
			apb(1'b1, 8'h00, {29'h0, i[2:0]});
			if (i[1:0] == 2'h2) begin
				repeat (20) @(posedge clk);
				apb(1'b0, 8'h04, 32'h0);
				chk("down", 32'h00000002, rd);
			end else begin
				conv(i[2:0], 1'b0);
				conv(i[2:0], 1'b0);
			end
		end
		// reset while asleep must bring back the powered idle state
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, 8'h04, 32'h0);
		chk("reset status", 32'h00000018, rd);
		apb(1'b1, 8'h00, 32'h0);
		repeat (20) @(posedge clk);
		conv(3'h0, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		chk("readback", {20'h0, lastE}, rd);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h00000000, rd);
		apb(1'b0, 8'h04, 32'h0);
		chk("status", 32'h00000018, rd);
		results();
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		results();
	end
endmodule // apc_power_ctrl_tb
